// ### design/aifs_map.vh
/*
 Register map, function codes and timing constants of the auxiliary input selector.
 Assumes a 100 MHz system clock and an APB slave with 32-bit data.
*/
`ifndef AIFS_MAP_VH
`define AIFS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AIFS_OFF_CTRL      12'h000
`define AIFS_OFF_STATUS    12'h004
`define AIFS_OFF_ALMDLY    12'h008
`define AIFS_OFF_CMD       12'h00C
`define AIFS_OFF_RELAY     12'h010
`define AIFS_OFF_SETTING   12'h014
`define AIFS_OFF_DEFAULT   12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AIFS_CTRL_FSEL_LSB  0
`define AIFS_CTRL_FSEL_MSB  4
`define AIFS_CTRL_STARTUP   8
`define AIFS_CTRL_SERVICE   9
`define AIFS_CTRL_ALMLED    10
`define AIFS_CTRL_STOPPED   11
`define AIFS_CTRL_SESS_LSB  12
`define AIFS_CTRL_SESS_MSB  13
`define AIFS_CMD_STORE      0
`define AIFS_CMD_RESTORE    1
`define AIFS_ST_LEVEL       0
`define AIFS_ST_DOOR_OPEN   1
`define AIFS_ST_ALARM       2
`define AIFS_ST_STOP        3
`define AIFS_ST_NIGHT       4
`define AIFS_ST_APPALT      5
`define AIFS_ST_LIGHT       6
`define AIFS_ST_SEPALM      7
`define AIFS_ST_BLIND       8
`define AIFS_ST_DEFCNT_LSB  16
`define AIFS_ST_DEFCNT_MSB  23
`define AIFS_ST_CLNCNT_LSB  24
`define AIFS_ST_CLNCNT_MSB  31

// ----------------------------------------------------------------
// Function codes and sessions
// ----------------------------------------------------------------
`define AIFS_FN_STATUS    5'h01
`define AIFS_FN_DOOR      5'h02
`define AIFS_FN_ALARM     5'h03
`define AIFS_FN_DEFROST   5'h04
`define AIFS_FN_MAINSW    5'h05
`define AIFS_FN_NIGHT     5'h06
`define AIFS_FN_APPCHG    5'h07
`define AIFS_FN_LIGHT     5'h08
`define AIFS_FN_SEPALM    5'h09
`define AIFS_FN_CLEAN     5'h0A
`define AIFS_FN_BLIND     5'h0C
`define AIFS_FN_ALMLED    5'h11
`define AIFS_FN_OPLED     5'h12
`define AIFS_SESS_USER    2'h0
`define AIFS_SESS_SERVICE 2'h1
`define AIFS_SESS_OEM     2'h2

// ----------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------
`define AIFS_CLK_HZ        100000000
`define AIFS_QUAL_MS       1000
`define AIFS_MS_PER_S      1000
`define AIFS_QUAL_CYCLES   ((`AIFS_CLK_HZ / `AIFS_MS_PER_S) * `AIFS_QUAL_MS)
`define AIFS_MIN_SEC       60
`define AIFS_CTRL_RESET    32'h00000100
`define AIFS_ZERO          32'h00000000

`endif

// ### design/aifs_top.v
/*
 Auxiliary input qualifier and function selector with an APB register slave.
 Assumes the contact input is synchronous to clk_sys and a single clock domain.
*/
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "aifs_map.vh"

module aifs_top #(
	parameter QUAL_CYCLES = `AIFS_QUAL_CYCLES,
	parameter SEC_CYCLES  = `AIFS_QUAL_CYCLES,
	parameter NRELAY      = 5
) (
	input  wire        clk_sys,
	input  wire        resetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        aux_input,
	output reg         aux_pin_out,
	output reg         aux_pin_oe_n,
	input  wire [NRELAY-1:0] relay_req,
	output reg  [NRELAY-1:0] relay_out,
	output reg         door_open,
	output reg         input_alarm,
	output reg         defrost_start,
	output reg         force_stop,
	output reg         night_setback,
	output reg         app_alternate,
	output reg         light_on,
	output reg         separate_alarm,
	output reg         clean_step,
	output reg         blind_down,
	output reg         restore_pulse
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg [31:0] ctrl_reg;
	reg [7:0]  input_alarm_delay_reg;
	reg [NRELAY-1:0] service_relay_reg;
	reg [31:0] setting_reg;
	reg [31:0] default_reg;
	reg [7:0]  defrost_cnt_reg;
	reg [7:0]  clean_cnt_reg;
	reg [31:0] qual_cnt_reg;
	reg        level_reg;
	reg        level_d_reg;
	reg [31:0] sec_cnt_reg;
	reg [7:0]  min_cnt_reg;
	reg [7:0]  alm_min_reg;

	wire [4:0] fsel    = ctrl_reg[`AIFS_CTRL_FSEL_MSB:`AIFS_CTRL_FSEL_LSB];
	wire [1:0] session = ctrl_reg[`AIFS_CTRL_SESS_MSB:`AIFS_CTRL_SESS_LSB];
	wire       startup = ctrl_reg[`AIFS_CTRL_STARTUP];
	wire       service = ctrl_reg[`AIFS_CTRL_SERVICE];
	wire       wr_en   = psel & penable & pwrite;
	wire       rise    = level_reg & ~level_d_reg;

	function sel_is;
		input [4:0] f;
		input [4:0] code;
		begin
			sel_is = (f == code);
		end
	endfunction

	wire wr_cmd    = wr_en && (paddr == `AIFS_OFF_CMD);
	wire store_ok  = wr_cmd && pwdata[`AIFS_CMD_STORE] && (session == `AIFS_SESS_OEM);
	wire restore_ok = wr_cmd && pwdata[`AIFS_CMD_RESTORE] &&
		((session == `AIFS_SESS_OEM) || (session == `AIFS_SESS_SERVICE));

	// ----------------------------------------------------------------
	// Input qualification
	// ----------------------------------------------------------------
	// Raw input high means closed contact, i.e. ON
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			qual_cnt_reg <= `AIFS_ZERO;
			level_reg    <= 1'b0;
			level_d_reg  <= 1'b0;
		end else begin
			level_d_reg <= level_reg;
			if (aux_input == level_reg) begin
				qual_cnt_reg <= `AIFS_ZERO;
			end else if (qual_cnt_reg >= QUAL_CYCLES - 1) begin
				level_reg    <= aux_input;
				qual_cnt_reg <= `AIFS_ZERO;
			end else begin
				qual_cnt_reg <= qual_cnt_reg + 32'h00000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Alarm delay timer, in minutes of qualified ON time
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sec_cnt_reg <= `AIFS_ZERO;
			min_cnt_reg <= 8'h00;
			alm_min_reg <= 8'h00;
		end else if (!(level_reg && sel_is(fsel, `AIFS_FN_ALARM))) begin
			sec_cnt_reg <= `AIFS_ZERO;
			min_cnt_reg <= 8'h00;
			alm_min_reg <= 8'h00;
		end else if (sec_cnt_reg >= SEC_CYCLES - 1) begin
			sec_cnt_reg <= `AIFS_ZERO;
			if (min_cnt_reg >= `AIFS_MIN_SEC - 1) begin
				min_cnt_reg <= 8'h00;
				if (alm_min_reg != 8'hFF)
					alm_min_reg <= alm_min_reg + 8'h01;
			end else begin
				min_cnt_reg <= min_cnt_reg + 8'h01;
			end
		end else begin
			sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// Function routing
	// ----------------------------------------------------------------
	// Codes 0, 1, 11, 13, 14, 21-23 fall through to no action
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			door_open      <= 1'b0;
			input_alarm    <= 1'b0;
			defrost_start  <= 1'b0;
			force_stop     <= 1'b0;
			night_setback  <= 1'b0;
			app_alternate  <= 1'b0;
			light_on       <= 1'b0;
			separate_alarm <= 1'b0;
			clean_step     <= 1'b0;
			blind_down     <= 1'b0;
			aux_pin_out    <= 1'b0;
			aux_pin_oe_n   <= 1'b1;
			defrost_cnt_reg <= 8'h00;
			clean_cnt_reg  <= 8'h00;
		end else begin
			door_open      <= sel_is(fsel, `AIFS_FN_DOOR) & level_reg;
			input_alarm    <= sel_is(fsel, `AIFS_FN_ALARM) & level_reg &
				(alm_min_reg >= input_alarm_delay_reg);
			defrost_start  <= sel_is(fsel, `AIFS_FN_DEFROST) & rise;
			force_stop     <= sel_is(fsel, `AIFS_FN_MAINSW) & ~level_reg;
			night_setback  <= sel_is(fsel, `AIFS_FN_NIGHT) & level_reg;
			app_alternate  <= sel_is(fsel, `AIFS_FN_APPCHG) & level_reg;
			light_on       <= sel_is(fsel, `AIFS_FN_LIGHT) & level_reg;
			separate_alarm <= sel_is(fsel, `AIFS_FN_SEPALM) & ~level_reg;
			clean_step     <= sel_is(fsel, `AIFS_FN_CLEAN) & rise;
			if (sel_is(fsel, `AIFS_FN_DEFROST) && rise)
				defrost_cnt_reg <= defrost_cnt_reg + 8'h01;
			if (sel_is(fsel, `AIFS_FN_CLEAN) && rise)
				clean_cnt_reg <= clean_cnt_reg + 8'h01;
			if (sel_is(fsel, `AIFS_FN_BLIND) && rise)
				blind_down <= ~blind_down;
			// Pin is only driven in the LED modes; otherwise it is an input
			if (sel_is(fsel, `AIFS_FN_ALMLED)) begin
				aux_pin_oe_n <= 1'b0;
				aux_pin_out  <= ctrl_reg[`AIFS_CTRL_ALMLED];
			end else if (sel_is(fsel, `AIFS_FN_OPLED)) begin
				aux_pin_oe_n <= 1'b0;
				aux_pin_out  <= ~ctrl_reg[`AIFS_CTRL_STOPPED];
			end else begin
				aux_pin_oe_n <= 1'b1;
				aux_pin_out  <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Relay gating
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NRELAY; gi = gi + 1) begin : g_relay
			always @(posedge clk_sys or negedge resetn) begin
				if (!resetn)
					relay_out[gi] <= 1'b0;
				else if (startup)
					relay_out[gi] <= 1'b0;
				else if (service)
					relay_out[gi] <= service_relay_reg[gi];
				else
					relay_out[gi] <= relay_req[gi];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// APB slave and settings store
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg              <= `AIFS_CTRL_RESET;
			input_alarm_delay_reg <= 8'h00;
			service_relay_reg     <= {NRELAY{1'b0}};
			setting_reg           <= `AIFS_ZERO;
			default_reg           <= `AIFS_ZERO;
			restore_pulse         <= 1'b0;
			prdata                <= `AIFS_ZERO;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
		end else begin
			restore_pulse <= restore_ok;
			// Zero-wait slave: pready rises in the setup cycle's following edge
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
				`AIFS_OFF_CTRL:    prdata <= ctrl_reg;
				`AIFS_OFF_STATUS:  prdata <= {clean_cnt_reg, defrost_cnt_reg, 7'h00,
					blind_down, separate_alarm, light_on, app_alternate,
					night_setback, force_stop, input_alarm, door_open,
					level_reg};
				`AIFS_OFF_ALMDLY:  prdata <= {24'h000000, input_alarm_delay_reg};
				`AIFS_OFF_CMD:     prdata <= `AIFS_ZERO;
				`AIFS_OFF_RELAY:   prdata <= {{(32-NRELAY){1'b0}}, relay_out};
				`AIFS_OFF_SETTING: prdata <= setting_reg;
				`AIFS_OFF_DEFAULT: prdata <= default_reg;
				default: begin
					prdata  <= `AIFS_ZERO;
					pslverr <= 1'b1;
				end
				endcase
			end
			if (wr_en && paddr == `AIFS_OFF_CTRL)
				ctrl_reg <= pwdata;
			if (wr_en && paddr == `AIFS_OFF_ALMDLY)
				input_alarm_delay_reg <= pwdata[7:0];
			if (wr_en && paddr == `AIFS_OFF_RELAY)
				service_relay_reg <= pwdata[NRELAY-1:0];
			if (store_ok)
				default_reg <= setting_reg;
			if (restore_ok)
				setting_reg <= default_reg;
			else if (wr_en && paddr == `AIFS_OFF_SETTING)
				setting_reg <= pwdata;
		end
	end

endmodule

// ### verification/aifs_checker.sv
/*
 Checker on the ports of aifs_top.
 Assumes a bind from the bench, one clock and an async low reset.
*/
`timescale 1ns/100ps
module aifs_checker #(
	parameter QUAL_CYCLES = 20,
	parameter SEC_CYCLES  = 4,
	parameter NRELAY      = 5
) (
	input wire              clk_sys,
	input wire              resetn,
	input wire              psel,
	input wire              penable,
	input wire              pwrite,
	input wire [11:0]       paddr,
	input wire [31:0]       pwdata,
	input wire              pready,
	input wire              pslverr,
	input wire              aux_input,
	input wire              aux_pin_out,
	input wire              aux_pin_oe_n,
	input wire [NRELAY-1:0] relay_out,
	input wire              defrost_start,
	input wire              clean_step,
	input wire              restore_pulse
);
	reg        aux_d;
	reg        wr_seen;
	reg [31:0] stab_cnt;
	// Run length of the raw level, so an edge can be tied to a stable span
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aux_d    <= 1'b0;
			wr_seen  <= 1'b0;
			stab_cnt <= 32'h0;
		end else begin
			aux_d    <= aux_input;
			wr_seen  <= wr_seen | (psel & penable & pwrite);
			stab_cnt <= (aux_input == aux_d) ? stab_cnt + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_access_ready: assert property (psel && !penable |=> pready)
		else $error("no pready in access");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_defrost_pulse: assert property (defrost_start |=> !defrost_start)
		else $error("defrost pulse long");
	a_clean_pulse: assert property (clean_step |=> !clean_step)
		else $error("clean pulse long");
	a_defrost_qual: assert property ($rose(defrost_start) |-> $past(stab_cnt) >= QUAL_CYCLES - 3)
		else $error("defrost unqualified");
	a_restore_cause: assert property ($rose(restore_pulse) |->
		$past(psel && penable && pwrite && paddr == 12'h00C && pwdata[1]))
		else $error("restore without command");
	a_startup_off: assert property (!wr_seen |-> relay_out == {NRELAY{1'b0}})
		else $error("relay on in start-up");
	a_pin_idle: assert property (aux_pin_oe_n |-> !aux_pin_out)
		else $error("pin driven while off");
	c_restore: cover property (restore_pulse);
	c_error: cover property (pslverr);
	c_defrost: cover property ($rose(defrost_start));
endmodule

// ### verification/aifs_contact.sv
/*
 Switch contact model on the auxiliary input.
 Assumes the bench changes closed and bounce right after a rising edge.
*/
`timescale 1ns/100ps
module aifs_contact (
	input  wire clk_sys,
	input  wire closed,
	input  wire bounce,
	output reg  aux_input
);
	reg [2:0] chatter_reg;
	initial aux_input = 1'b0;
	initial chatter_reg = 3'h0;
	// Chatter is shorter than the qualify span, so it must never be seen
	always @(posedge clk_sys) begin
		if (bounce && chatter_reg == 3'h0 && closed != aux_input)
			chatter_reg <= 3'h6;
		if (chatter_reg != 3'h0) begin
			chatter_reg <= chatter_reg - 3'h1;
			aux_input   <= ~aux_input;
		end else
			aux_input <= closed;
	end
endmodule

// ### verification/aifs_top_tb.sv
/*
 Bench for aifs_top: APB tasks and call sequences with expected values.
 Assumes the checker and contact model are compiled first.
*/
`timescale 1ns/100ps
module aifs_top_tb;
	localparam QUAL = 20;
	localparam SEC  = 4;
	reg         clk_sys, resetn, psel, penable, pwrite, closed, bounce, err;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	reg  [4:0]  relay_req;
	integer     failures, n_compared, n_def, n_cln, n_rst, c;
	wire [31:0] prdata;
	wire [4:0]  relay_out;
	wire        pready, pslverr, aux_input, aux_pin_out, aux_pin_oe_n, door_open;
	wire        input_alarm, defrost_start, force_stop, night_setback, app_alternate;
	wire        light_on, separate_alarm, clean_step, blind_down, restore_pulse;
	wire [8:0]  lv = {door_open, force_stop, night_setback, app_alternate, light_on,
		separate_alarm, input_alarm, aux_pin_oe_n, aux_pin_out};
	aifs_top #(.QUAL_CYCLES(QUAL), .SEC_CYCLES(SEC), .NRELAY(5)) DUT (
		.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .aux_input(aux_input),
		.aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n), .relay_req(relay_req),
		.relay_out(relay_out), .door_open(door_open), .input_alarm(input_alarm),
		.defrost_start(defrost_start), .force_stop(force_stop),
		.night_setback(night_setback), .app_alternate(app_alternate), .light_on(light_on),
		.separate_alarm(separate_alarm), .clean_step(clean_step),
		.blind_down(blind_down), .restore_pulse(restore_pulse));
	aifs_contact u_contact (.clk_sys(clk_sys), .closed(closed), .bounce(bounce),
		.aux_input(aux_input));
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_def = n_def + (defrost_start === 1'b1);
		n_cln = n_cln + (clean_step === 1'b1);
		n_rst = n_rst + (restore_pulse === 1'b1);
	end
	function [8:0] exp_lv(input integer k, input integer on);
		exp_lv = {k == 2 && on, k == 5 && !on, k == 6 && on, k == 7 && on, k == 8 && on,
			k == 9 && !on, k == 3 && on, k != 17 && k != 18, k == 18};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input wr, input [11:0] a, input [31:0] d);
		begin
			psel    <= 1'b1;
			pwrite  <= wr;
			paddr   <= a;
			pwdata  <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			@(posedge clk_sys);
			while (pready !== 1'b1)
				@(posedge clk_sys);
			rd = prdata;
			err = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
			// Idle edge so a following call never reassigns psel in this step
			@(posedge clk_sys);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input [11:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk(rd, exp);
		end
	endtask
	task settle(input on);
		begin
			closed <= on;
			repeat (QUAL + 16) @(posedge clk_sys);
		end
	endtask
	task give_verdict;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures = failures + 1;
		give_verdict;
	end
	initial begin
		{clk_sys, resetn, psel, penable, pwrite, closed, bounce} = 7'h0;
		{paddr, pwdata, relay_req} = {12'h0, 32'h0, 5'h15};
		{failures, n_compared, n_def, n_cln, n_rst} = 160'h0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rdc(12'h000, 32'h100);
		chk(relay_out, 32'h0);
		rdc(12'h01C, 32'h0);
		chk(err, 32'h1);
		wr(12'h000, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk(relay_out, 32'h15);
		wr(12'h010, 32'h0A);
		wr(12'h000, 32'h200);
		rdc(12'h010, 32'h0A);
		bounce <= 1'b1;
		// Every supported code, with contact chatter on each change
		for (c = 0; c < 24; c = c + 1)
			if (c < 15 || c == 17 || c == 18 || c > 20) begin
				wr(12'h000, c);
				settle(1'b1);
				chk(lv, exp_lv(c, 1));
				apb(1'b0, 12'h004, 32'h0);
				chk(rd & 32'h1, 32'h1);
				settle(1'b0);
				chk(lv, exp_lv(c, 0));
				if (c == 12)
					chk(blind_down, 32'h1);
			end
		chk(n_def, 32'h1);
		chk(n_cln, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd & 32'hFFFF0000, 32'h01010000);
		wr(12'h008, 32'h1);
		wr(12'h000, 32'h3);
		settle(1'b1);
		repeat (150) @(posedge clk_sys);
		chk(input_alarm, 32'h0);
		repeat (100) @(posedge clk_sys);
		chk(input_alarm, 32'h1);
		settle(1'b0);
		wr(12'h000, 32'h411);
		repeat (3) @(posedge clk_sys);
		chk({aux_pin_oe_n, aux_pin_out}, 32'h1);
		wr(12'h000, 32'h812);
		repeat (3) @(posedge clk_sys);
		chk({aux_pin_oe_n, aux_pin_out}, 32'h0);
		wr(12'h014, 32'h5A);
		wr(12'h000, 32'h1000);
		wr(12'h00C, 32'h1);
		rdc(12'h018, 32'h0);
		wr(12'h000, 32'h2000);
		wr(12'h00C, 32'h1);
		rdc(12'h018, 32'h5A);
		wr(12'h014, 32'h33);
		wr(12'h000, 32'h0);
		wr(12'h00C, 32'h2);
		rdc(12'h014, 32'h33);
		wr(12'h000, 32'h1000);
		wr(12'h00C, 32'h2);
		rdc(12'h014, 32'h5A);
		chk(n_rst, 32'h1);
		give_verdict;
	end
endmodule
bind aifs_top aifs_checker #(
	.QUAL_CYCLES(QUAL_CYCLES), .SEC_CYCLES(SEC_CYCLES), .NRELAY(NRELAY)
) u_checker (
	.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.aux_input(aux_input), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
	.relay_out(relay_out), .defrost_start(defrost_start), .clean_step(clean_step),
	.restore_pulse(restore_pulse));
